// >>> logic/scss_clk_map.vh
`ifndef SCSS_CLK_MAP_VH
`define SCSS_CLK_MAP_VH

// clock_source_select codes
`define SCSS_SEL_WAKEUP 2'h0
`define SCSS_SEL_PLL_PRE 2'h2
`define SCSS_SEL_DIRECT 2'h3

// vco_band_select codes
`define SCSS_BAND_LOW 2'h0
`define SCSS_BAND_HIGH 2'h1

// field widths
`define SCSS_K1_W 10
`define SCSS_P_W 4
`define SCSS_N_W 7
`define SCSS_K2_W 7
`define SCSS_PER_W 16
`define SCSS_ACC_W 24

// synchronised source index
`define SCSS_IDX_DIRECT 0
`define SCSS_IDX_OSC 1
`define SCSS_IDX_ONCHIP 2
`define SCSS_IDX_WAKEUP 3

// reset value of the estimated reference period
`define SCSS_PER_RST 16'h0000

`endif

// >>> logic/scss_sync2.v
`timescale 1ns/1ps
// two-stage synchroniser for one asynchronous pin
module scss_sync2 (
  input wire i_sys_clk, // system clock
  input wire i_rst_b,   // async reset, active low
  input wire i_async,   // asynchronous level
  output wire o_sync    // synchronised level
);
  reg meta_ff;
  reg sync_ff;

  // first stage feeds only the second stage
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule // scss_sync2

// >>> logic/scss_clk_select.v
// Function
// R1: select 11 passes direct clock pin unchanged
// R2: select 10, bypass 1: source divided by K1
// R3: prescale factor reaches 1024
// R4: factor one follows source duty cycle
// R5: select 10, bypass 0: PLL output drives clock
// R6: PLL clock is input times N over P*K2
// R7: PLL reference is oscillator pin or on-chip
// R8: PLL period estimate slews gradually, never jumps; the code takes the first estimate whole
// R9: system clock is VCO divided by K2
// R10: band field picks low or high VCO band
// R11: select 00 runs from wakeup clock
// R12: software writes all fields consistently
// R13: source switches happen glitch-free; the code forces a high clock low as soon as a change is seen
`timescale 1ns/1ps
`include "scss_clk_map.vh"
module scss_clk_select #(
  parameter K1_W = `SCSS_K1_W,
  parameter P_W = `SCSS_P_W,
  parameter N_W = `SCSS_N_W,
  parameter K2_W = `SCSS_K2_W,
  parameter PER_W = `SCSS_PER_W,
  parameter ACC_W = `SCSS_ACC_W
) (
  input wire i_sys_clk,                      // 25 MHz sampling clock
  input wire i_rst_b,                        // async reset, active low
  input wire i_direct_clock_pin,             // direct clock input pin
  input wire i_oscillator_input_pin,         // oscillator input pin
  input wire i_onchip_clk,                   // on-chip clock source
  input wire i_wakeup_clk,                   // low-frequency wakeup clock
  input wire [1:0] i_clock_source_select,    // source select field
  input wire i_vco_bypass,                   // 1 prescaler, 0 PLL
  input wire i_ref_onchip,                   // 1 on-chip, 0 oscillator pin
  input wire [K1_W-1:0] i_prescale_divide_field,   // K1 minus one
  input wire [P_W-1:0] i_input_divide_field,       // P minus one
  input wire [N_W-1:0] i_feedback_multiply_field,  // N minus one
  input wire [K2_W-1:0] i_output_divide_field,     // K2 minus one
  input wire [1:0] i_vco_band_select,        // VCO band field
  output wire o_sys_clk,                     // generated system clock
  output wire o_pll_enable,                  // PLL running
  output wire o_vco_band_high,               // high VCO band in use
  output wire o_pll_locked,                  // estimate matches reference
  output wire o_switch_pending               // waiting to switch safely
);
  localparam MODE_WAKEUP = 2'h0;
  localparam MODE_DIRECT = 2'h1;
  localparam MODE_PRESCALE = 2'h2;
  localparam MODE_PLL = 2'h3;

  // decode of select and bypass, used for request and active setting
  function [1:0] scss_mode;
    input [1:0] sel;
    input byp;
    begin
      case (sel)
        `SCSS_SEL_DIRECT: scss_mode = MODE_DIRECT;
        `SCSS_SEL_PLL_PRE: scss_mode = byp ? MODE_PRESCALE : MODE_PLL;
        default: scss_mode = MODE_WAKEUP;
      endcase
    end
  endfunction

  wire [3:0] pin_async;
  wire [3:0] pin_s;
  reg [3:0] pin_d_ff;

  assign pin_async = {i_wakeup_clk, i_onchip_clk, i_oscillator_input_pin,
                      i_direct_clock_pin};

  // every source pin crosses two flops before use
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      scss_sync2 u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_async(pin_async[gi]),
        .o_sync(pin_s[gi])
      );
    end
  endgenerate

  reg [1:0] mode_ff;
  reg ref_ff;
  reg [1:0] band_ff;
  reg [K1_W-1:0] k1_ff;
  reg [P_W-1:0] p_ff;
  reg [N_W-1:0] n_ff;
  reg [K2_W-1:0] k2_ff;
  reg out_ff;
  reg [K1_W-1:0] div_cnt_ff;
  reg [K2_W-1:0] k2_cnt_ff;
  reg [PER_W-1:0] per_cnt_ff;
  reg [PER_W-1:0] per_est_ff;
  reg [PER_W-1:0] per_meas_ff;
  reg [ACC_W-1:0] acc_ff;

  wire [1:0] req_mode;
  wire change;
  wire ref_lvl;
  wire ref_edge;
  wire ref_rise;
  wire [ACC_W-1:0] step;
  wire [ACC_W-1:0] thresh;
  wire [ACC_W-1:0] acc_sum;
  wire vco_edge;

  assign req_mode = scss_mode(i_clock_source_select, i_vco_bypass);
  // any difference in decoded mode or in a field counts as a change request
  assign change = (req_mode != mode_ff) ||
                  (i_ref_onchip != ref_ff) ||
                  (i_vco_band_select != band_ff) ||
                  (i_prescale_divide_field != k1_ff) ||
                  (i_input_divide_field != p_ff) ||
                  (i_feedback_multiply_field != n_ff) ||
                  (i_output_divide_field != k2_ff);

  // reference is oscillator pin or on-chip source
  assign ref_lvl = ref_ff ? pin_s[`SCSS_IDX_ONCHIP] :
                   pin_s[`SCSS_IDX_OSC]; // [R7]
  assign ref_edge = ref_lvl ^ (ref_ff ? pin_d_ff[`SCSS_IDX_ONCHIP] :
                    pin_d_ff[`SCSS_IDX_OSC]);
  assign ref_rise = ref_edge & ref_lvl;

  // vco half-periods: 2N edges in every P reference periods
  assign step = {{(ACC_W-N_W-1){1'b0}}, n_ff, 1'b0} +
                {{(ACC_W-2){1'b0}}, 2'h2}; // [R6]
  // estimate widened on purpose so the product keeps all its bits
  assign thresh = {{(ACC_W-PER_W){1'b0}}, per_est_ff} *
                  ({{(ACC_W-P_W){1'b0}}, p_ff} +
                  {{(ACC_W-1){1'b0}}, 1'b1});
  assign acc_sum = acc_ff + step;
  assign vco_edge = (per_est_ff != `SCSS_PER_RST) && (acc_sum >= thresh);

  // previous synchronised levels for edge detection
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_d_ff <= 4'h0;
    end else begin
      pin_d_ff <= pin_s;
    end
  end

  // configuration is adopted only while the clock is low, then
  // dividers restart; a high phase under way is cut short once the change is seen
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_ff <= MODE_WAKEUP;
      ref_ff <= 1'b0;
      band_ff <= `SCSS_BAND_LOW;
      k1_ff <= {K1_W{1'b0}};
      p_ff <= {P_W{1'b0}};
      n_ff <= {N_W{1'b0}};
      k2_ff <= {K2_W{1'b0}};
    end else if (change && !out_ff) begin // [R13]
      mode_ff <= req_mode;
      ref_ff <= i_ref_onchip;
      band_ff <= i_vco_band_select;
      k1_ff <= i_prescale_divide_field;
      p_ff <= i_input_divide_field;
      n_ff <= i_feedback_multiply_field;
      k2_ff <= i_output_divide_field;
    end
  end

  // reference period measurement with slew-limited estimate
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      per_cnt_ff <= {PER_W{1'b0}};
      per_meas_ff <= {PER_W{1'b0}};
      per_est_ff <= `SCSS_PER_RST;
    end else if (mode_ff != MODE_PLL) begin
      per_cnt_ff <= {PER_W{1'b0}};
      per_meas_ff <= {PER_W{1'b0}};
      per_est_ff <= `SCSS_PER_RST;
    end else if (ref_rise) begin
      per_cnt_ff <= {{(PER_W-1){1'b0}}, 1'b1};
      per_meas_ff <= per_cnt_ff;
      // first estimate taken whole; later ones move one step only
      if (per_est_ff == `SCSS_PER_RST) begin
        per_est_ff <= per_meas_ff;
      end else if (per_meas_ff > per_est_ff) begin
        per_est_ff <= per_est_ff + {{(PER_W-1){1'b0}}, 1'b1}; // [R8]
      end else if (per_meas_ff < per_est_ff) begin
        per_est_ff <= per_est_ff - {{(PER_W-1){1'b0}}, 1'b1}; // [R8]
      end
    end else if (per_cnt_ff != {PER_W{1'b1}}) begin
      per_cnt_ff <= per_cnt_ff + {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

  // output generation for the active mode
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_ff <= 1'b0;
      div_cnt_ff <= {K1_W{1'b0}};
      k2_cnt_ff <= {K2_W{1'b0}};
      acc_ff <= {ACC_W{1'b0}};
    end else if (change) begin
      // drive low and hold until the new setting is taken
      out_ff <= 1'b0;
      div_cnt_ff <= {K1_W{1'b0}};
      k2_cnt_ff <= {K2_W{1'b0}};
      acc_ff <= {ACC_W{1'b0}};
    end else begin
      case (mode_ff)
        MODE_DIRECT: begin
          out_ff <= pin_s[`SCSS_IDX_DIRECT]; // [R1]
        end
        MODE_WAKEUP: begin
          out_ff <= pin_s[`SCSS_IDX_WAKEUP]; // [R11]
        end
        MODE_PRESCALE: begin
          // each source edge counts; K1 edges per output edge
          if (k1_ff == {K1_W{1'b0}}) begin
            out_ff <= ref_lvl; // [R4]
          end else if (ref_edge) begin
            if (div_cnt_ff == k1_ff) begin // [R2] [R3]
              div_cnt_ff <= {K1_W{1'b0}};
              out_ff <= ~out_ff;
            end else begin
              div_cnt_ff <= div_cnt_ff + {{(K1_W-1){1'b0}}, 1'b1};
            end
          end
        end
        MODE_PLL: begin
          // one vco edge per cycle at most limits model speed; band is not used here
          if (vco_edge) begin
            acc_ff <= acc_sum - thresh;
            if (k2_cnt_ff == k2_ff) begin // [R9] [R5]
              k2_cnt_ff <= {K2_W{1'b0}};
              out_ff <= ~out_ff;
            end else begin
              k2_cnt_ff <= k2_cnt_ff + {{(K2_W-1){1'b0}}, 1'b1};
            end
          end else if (per_est_ff != `SCSS_PER_RST) begin
            acc_ff <= acc_sum;
          end
        end
        default: begin
          out_ff <= 1'b0;
        end
      endcase
    end
  end

  assign o_sys_clk = out_ff;
  assign o_pll_enable = (mode_ff == MODE_PLL); // [R5]
  assign o_vco_band_high = (band_ff == `SCSS_BAND_HIGH); // [R10]
  assign o_pll_locked = (mode_ff == MODE_PLL) &&
                        (per_est_ff != `SCSS_PER_RST) &&
                        (per_est_ff == per_meas_ff);
  assign o_switch_pending = change;
endmodule // scss_clk_select

// >>> tb/scss_clk_select_monitor.sv
`timescale 1ns/1ps
// checker watching only the top-level ports of the clock selector
module scss_mon #(
  parameter K1_W = 10,
  parameter P_W = 4,
  parameter N_W = 7,
  parameter K2_W = 7
) (
  input wire i_sys_clk, // clock
  input wire i_rst_b, // reset
  input wire i_direct_clock_pin, // direct pin
  input wire i_oscillator_input_pin, // osc pin
  input wire i_onchip_clk, // on-chip
  input wire i_wakeup_clk, // wakeup
  input wire [1:0] i_clock_source_select, // select
  input wire i_vco_bypass, // bypass
  input wire i_ref_onchip, // reference
  input wire [K1_W-1:0] i_prescale_divide_field, // k1
  input wire [P_W-1:0] i_input_divide_field, // p
  input wire [N_W-1:0] i_feedback_multiply_field, // n
  input wire [K2_W-1:0] i_output_divide_field, // k2
  input wire [1:0] i_vco_band_select, // band
  input wire o_sys_clk, // clock out
  input wire o_pll_enable, // pll on
  input wire o_vco_band_high, // band high
  input wire o_pll_locked, // locked
  input wire o_switch_pending // pending
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // decoded modes; pending low means inputs equal the adopted setup
  wire pll_sel = i_clock_source_select == 2'h2 && !i_vco_bypass;
  wire k1_unit = i_clock_source_select == 2'h2 && i_vco_bypass &&
    i_prescale_divide_field == 0 && !i_ref_onchip;
  a_pll_on_mode: assert property (o_pll_enable && !o_switch_pending
    |-> pll_sel) else $error("pll enabled outside pll mode");
  a_pll_off_mode: assert property (!o_switch_pending && !pll_sel
    |-> !o_pll_enable) else $error("pll left running");
  a_band_report: assert property (!o_switch_pending
    |-> o_vco_band_high == (i_vco_band_select == 2'h1))
    else $error("band flag wrong");
  a_direct_follow: assert property ((!o_switch_pending &&
    i_clock_source_select == 2'h3)[*4]
    |-> o_sys_clk == $past(i_direct_clock_pin, 3))
    else $error("direct clock not followed");
  a_wakeup_follow: assert property ((!o_switch_pending &&
    i_clock_source_select == 2'h0)[*4]
    |-> o_sys_clk == $past(i_wakeup_clk, 3))
    else $error("wakeup clock not followed");
  a_k1_unity: assert property ((!o_switch_pending && k1_unit)[*4]
    |-> o_sys_clk == $past(i_oscillator_input_pin, 3))
    else $error("unity prescale not a pass-through");
  a_switch_low: assert property ($rose(o_switch_pending)
    |=> !o_sys_clk) else $error("clock not parked low on switch");
  a_pend_bound: assert property (o_switch_pending
    |-> ##[1:2] !o_switch_pending) else $error("switch never adopted");
  c_lock: cover property ($rose(o_pll_locked));
  c_switch: cover property ($fell(o_switch_pending));
  c_band: cover property (o_vco_band_high && o_pll_enable);
endmodule // scss_mon

bind scss_clk_select scss_mon #(.K1_W(K1_W), .P_W(P_W), .N_W(N_W),
  .K2_W(K2_W)) u_mon (.*);

// >>> tb/scss_src_model.sv
`timescale 1ns/1ps
// free-running sources; half periods are whole sample periods, so every
// source edge lands on a falling sample edge and never races the flops
module scss_src_model #(parameter int HD = 120, HO = 160, HC = 200,
  HW = 440) (
  output logic o_direct, // direct pin
  output logic o_osc, // oscillator pin
  output logic o_onchip, // on-chip clock
  output logic o_wakeup // wakeup clock
);
  // every level lasts over two sample cycles so none is lost
  initial {o_direct, o_osc, o_onchip, o_wakeup} = 4'h0;
  always #HD o_direct = ~o_direct;
  always #HO o_osc = ~o_osc;
  always #HC o_onchip = ~o_onchip;
  always #HW o_wakeup = ~o_wakeup;
endmodule // scss_src_model

// >>> tb/system_clock_source_select_tb_top.sv
`timescale 1ns/1ps
module system_clock_source_select_tb_top;
  logic i_sys_clk, i_rst_b, byp, refc, out, pen, bh, lk, pend, last;
  logic [1:0] sel, band;
  logic [9:0] k1;
  logic [3:0] p;
  logic [6:0] n, k2;
  wire [3:0] src;
  int miscompares, samples_checked, cyc, kk, w, rises[5];
  scss_src_model u_src (.o_direct(src[0]), .o_osc(src[1]),
    .o_onchip(src[2]), .o_wakeup(src[3]));
  scss_clk_select uut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_direct_clock_pin(src[0]), .i_oscillator_input_pin(src[1]),
    .i_onchip_clk(src[2]), .i_wakeup_clk(src[3]),
    .i_clock_source_select(sel), .i_vco_bypass(byp), .i_ref_onchip(refc),
    .i_prescale_divide_field(k1), .i_input_divide_field(p),
    .i_feedback_multiply_field(n), .i_output_divide_field(k2),
    .i_vco_band_select(band), .o_sys_clk(out), .o_pll_enable(pen),
    .o_vco_band_high(bh), .o_pll_locked(lk), .o_switch_pending(pend));
  initial begin
    i_sys_clk = 0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  // source rises counted per pin; the model reckons from these counts
  for (genvar g = 0; g < 4; g++) begin : g_cnt
    always @(posedge src[g]) rises[g]++;
  end
  // output rises seen at the sample clock, plus the hang limit
  always @(posedge i_sys_clk) begin
    last <= out;
    if (out === 1'b1 && last === 1'b0) rises[4]++;
    cyc++;
    if (cyc == 60000) begin
      $display("[ERR] %0t timeout", $time);
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(int got, int exp, int tol);
    samples_checked++;
    if (got < exp - tol || got > exp + tol) begin
      miscompares++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic chkb(logic got, logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // all fields move in one cycle so no half-written setup is seen
  task automatic cfg(logic [1:0] s, logic b, logic r, logic [9:0] d1,
    logic [3:0] dp, logic [6:0] dn, logic [6:0] dk, logic [1:0] bd);
    @(posedge i_sys_clk);
    {sel, byp, refc, k1, p, n, k2, band} <= {s, b, r, d1, dp, dn, dk, bd};
    repeat (3) @(posedge i_sys_clk);
    chkb(pend, 1'b0);
  endtask
  // expected output rises = source rises * num / den over the window
  task automatic measure(int idx, int num, int den, int len, int tol);
    int r0, s0;
    r0 = rises[4];
    s0 = rises[idx];
    repeat (len) @(posedge i_sys_clk);
    chk(rises[4] - r0, (rises[idx] - s0) * num / den, tol);
    $display("test on source %0d ratio %0d/%0d done", idx, num, den);
  endtask
  initial begin
    void'($urandom(32'he8b7));
    {sel, byp, refc, k1, p, n, k2, band, last} = '0;
    {miscompares, samples_checked, cyc} = '0;
    rises = '{default: 0};
    i_rst_b = 0;
    repeat (3) @(posedge i_sys_clk);
    i_rst_b <= 1;
    measure(3, 1, 1, 2000, 1);
    cfg(2'h3, 0, 0, 0, 0, 0, 0, 2'h0);
    measure(0, 1, 1, 1000, 1);
    for (int i = 0; i < 4; i++) begin
      kk = (i < 2) ? 0 : $urandom_range(1, 6);
      cfg(2'h2, 1, i[0], kk[9:0], 0, 0, 0, 2'h0);
      measure(1 + i[0], 1, kk + 1, 3000, 1);
    end
    cfg(2'h2, 1, 0, 10'h3ff, 0, 0, 0, 2'h0);
    measure(1, 1, 1024, 30000, 1);
    for (int i = 0; i < 2; i++) begin
      // random first band, the other band second, so both are seen
      kk = (i == 0) ? $urandom_range(0, 1) : 1 - kk;
      cfg(2'h2, 0, 0, 0, i[3:0], 7'h1 + 7'(2 * i), 7'h3 - 7'(2 * i),
        kk[1:0]);
      for (w = 0; w < 3000 && lk !== 1'b1; w++) @(posedge i_sys_clk);
      chkb(lk, 1'b1);
      chkb(pen, 1'b1);
      chkb(bh, kk[0]);
      measure(1, 2 + 2 * i, (i + 1) * (4 - 2 * i), 2000, 3);
    end
    cfg(2'h3, 0, 0, 0, 0, 0, 0, 2'h0);
    chkb(pen, 1'b0);
    give_verdict();
  end
  task give_verdict;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
endmodule // system_clock_source_select_tb_top
